/* File: src/otp_device.sv */
// Display driver end: command decoder, refresh timer and calibration load mode
// Operation
// - Shift register one burns its cell
// - Shift register zero leaves cell unchanged
// - Burned cell stays one forever
// - Host never reburns a cell reading one
// - Host burns one cell per pulse
// - Any order; seal bit burned last
// - Burned seal blocks calibration load mode
// - Host leaves power-save, waits 5 ms
// - Host re-enters power-down, then enters mode
// - Bytes carry D7 one, data D0, MSB first
// - Ninth byte seal, D7 kept one
// - Host pulses supplies after each load
// - Host ends session with external reset
// - Supplies only in power-down and mode
// - Pulse lasts 100 to 200 ms
// - D7 zero or reset leaves mode
// - Set shift register seal ignores entry
// - Mode uses only D7 and D0
// - Entry blocked until refresh completes
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module otp_device #(
	parameter int REFRESH_CYC = otp_pkg::REFRESH_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	otp_link_if.device lnk,
	output logic cal_mode,
	output logic refresh_busy,
	output logic refresh_done,
	output logic display_on,
	output logic all_pixels,
	output logic [1:0] power_bits,
	output logic [4:0] contrast_trim,
	output logic [2:0] temp_coeff_trim,
	output logic seal,
	output logic [8:0] otp_cells
);
	localparam int CNT_W = $clog2(REFRESH_CYC + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(REFRESH_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	function automatic logic cmd_match(input logic [7:0] b, input logic [7:0] mask, input logic [7:0] val);
		cmd_match = ((b & mask) == val);
	endfunction

	otp_pkg::dev_state_t state_r;
	otp_pkg::dev_state_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic busy_r;
	logic done_r;
	logic don_r;
	logic dal_r;
	logic [1:0] pc_r;
	logic cal_r;
	logic [8:0] shreg;
	logic [8:0] cells;

	wire soft_rst;
	wire byte_cmd;
	wire [7:0] b;
	wire in_save;
	wire in_normal;
	wire in_cal;
	wire hit_exit_save;
	wire hit_calibration_load_mode;
	wire hit_pwr;
	wire hit_disp;
	wire hit_dal;
	wire enter_ok;
	wire go_cal;
	wire cal_byte;
	wire cal_exit;
	wire refresh_start;
	wire refresh_end;
	wire burn;

	// External reset from the host acts as a synchronous clear of control state
	assign soft_rst = ~lnk.ext_reset_n;
	assign byte_cmd = lnk.byte_valid & ~lnk.byte_dc & ~lnk.byte_rw;
	assign b = lnk.byte_data;
	assign in_save = (state_r == otp_pkg::ST_SAVE);
	assign in_normal = (state_r == otp_pkg::ST_NORMAL);
	assign in_cal = (state_r == otp_pkg::ST_CALIBRATION_LOAD_MODE);
	assign hit_exit_save = byte_cmd & in_save & (b == otp_pkg::CMD_EXIT_SAVE);
	assign hit_calibration_load_mode = byte_cmd & in_normal & (b == otp_pkg::CMD_CALIBRATION_LOAD_MODE);
	assign hit_pwr = byte_cmd & ~in_cal & cmd_match(b, otp_pkg::CMD_PWR_MASK, otp_pkg::CMD_PWR_VAL);
	assign hit_disp = byte_cmd & in_normal & cmd_match(b, otp_pkg::CMD_DISP_MASK, otp_pkg::CMD_DISP_VAL);
	assign hit_dal = byte_cmd & in_normal & cmd_match(b, otp_pkg::CMD_DAL_MASK, otp_pkg::CMD_DAL_VAL);
	// Entry needs a finished refresh and a clear seal in the shift register
	assign enter_ok = done_r & ~shreg[otp_pkg::SEAL_POS];
	assign go_cal = hit_calibration_load_mode & enter_ok;
	// In the mode every command byte is data: D0 shifts, D7 continues
	assign cal_byte = byte_cmd & in_cal;
	assign cal_exit = cal_byte & ~b[otp_pkg::CONT_POS];
	// Power control refreshes, except while still in power-save
	assign refresh_start = hit_exit_save | (hit_pwr & in_normal);
	assign refresh_end = busy_r & (cnt_r == CNT_ONE);
	// Both supplies high while in the mode stand for the programming pulse
	assign burn = in_cal & lnk.prog_supply & lnk.lcd_supply;

	otp_cell_array u_cells (
		.hclk(hclk),
		.hresetn(hresetn),
		.clear_en(soft_rst),
		.shift_en(cal_byte),
		.shift_bit(b[otp_pkg::DATA_POS]),
		.load_en(refresh_end),
		.burn_en(burn),
		.shreg(shreg),
		.cells(cells)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			otp_pkg::ST_SAVE: begin
				if (hit_exit_save) begin
					state_nxt = otp_pkg::ST_NORMAL;
				end
			end
			otp_pkg::ST_NORMAL: begin
				if (go_cal) begin
					state_nxt = otp_pkg::ST_CALIBRATION_LOAD_MODE;
				end
			end
			otp_pkg::ST_CALIBRATION_LOAD_MODE: begin
				if (cal_exit) begin
					state_nxt = otp_pkg::ST_NORMAL;
				end
			end
			default: begin
				state_nxt = otp_pkg::ST_SAVE;
			end
		endcase
	end

	always_comb begin
		cnt_nxt = cnt_r;
		if (refresh_start) begin
			cnt_nxt = CNT_LOAD;
		end else if (busy_r) begin
			cnt_nxt = cnt_r - CNT_ONE;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= otp_pkg::ST_SAVE;
		end else if (soft_rst) begin
			state_r <= otp_pkg::ST_SAVE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else if (soft_rst) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			busy_r <= refresh_start | (busy_r & ~refresh_end);
		end
	end

	// Seal in the shift register is only trusted after a refresh
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_r <= 1'b0;
		end else if (soft_rst) begin
			done_r <= 1'b0;
		end else if (refresh_end) begin
			done_r <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_r <= otp_pkg::RST_PC;
			don_r <= otp_pkg::RST_DON;
			dal_r <= otp_pkg::RST_DAL;
		end else if (soft_rst) begin
			pc_r <= otp_pkg::RST_PC;
			don_r <= otp_pkg::RST_DON;
			dal_r <= otp_pkg::RST_DAL;
		end else begin
			if (hit_pwr) begin
				pc_r <= b[otp_pkg::PC_POS +: 2];
			end
			if (hit_disp) begin
				don_r <= b[otp_pkg::DON_POS];
			end
			if (hit_dal) begin
				dal_r <= b[otp_pkg::DAL_POS];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_r <= 1'b0;
		end else begin
			cal_r <= in_cal;
		end
	end

	assign cal_mode = cal_r;
	assign refresh_busy = busy_r;
	assign refresh_done = done_r;
	assign display_on = don_r;
	assign all_pixels = dal_r;
	assign power_bits = pc_r;
	assign contrast_trim = shreg[otp_pkg::CONTRAST_POS +: otp_pkg::CONTRAST_W];
	assign temp_coeff_trim = shreg[otp_pkg::TEMP_POS +: otp_pkg::TEMP_W];
	assign seal = shreg[otp_pkg::SEAL_POS];
	assign otp_cells = cells;
endmodule // otp_device

/* File: src/otp_pkg.sv */
// Shared constants and types for the calibration cell programming link
package otp_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int REFRESH_MS = 5;
	localparam int REFRESH_CYC = REFRESH_MS * CYC_PER_MS;
	localparam int PULSE_MIN_MS = 100;
	localparam int PULSE_TYP_MS = 120;
	localparam int PULSE_MAX_MS = 200;
	localparam int PULSE_CYC = PULSE_TYP_MS * CYC_PER_MS;
	localparam int OTP_BITS = 9;
	localparam int SEAL_POS = 0;
	localparam int TEMP_POS = 1;
	localparam int TEMP_W = 3;
	localparam int CONTRAST_POS = 4;
	localparam int CONTRAST_W = 5;
	localparam int CONT_POS = 7;
	localparam int DATA_POS = 0;
	localparam logic [7:0] CMD_EXIT_SAVE = 8'hE1;
	localparam logic [7:0] CMD_CALIBRATION_LOAD_MODE = 8'h82;
	localparam logic [7:0] CMD_PWR_MASK = 8'hF9;
	localparam logic [7:0] CMD_PWR_VAL = 8'h29;
	localparam int PC_POS = 1;
	localparam logic [7:0] CMD_DISP_MASK = 8'hFB;
	localparam logic [7:0] CMD_DISP_VAL = 8'hA9;
	localparam int DON_POS = 2;
	localparam logic [7:0] CMD_DAL_MASK = 8'hFE;
	localparam logic [7:0] CMD_DAL_VAL = 8'hA4;
	localparam int DAL_POS = 0;
	localparam logic RST_DON = 1'b0;
	localparam logic RST_DAL = 1'b0;
	localparam logic [1:0] RST_PC = 2'h0;
	localparam logic [8:0] RST_SHREG = 9'h000;
	localparam logic [8:0] RST_CELLS = 9'h000;
	localparam logic [31:0] REG_CMD = 32'h0000_0000;
	localparam logic [31:0] REG_CTRL = 32'h0000_0004;
	localparam logic [31:0] REG_STATUS = 32'h0000_0008;
	localparam int CMD_DC_POS = 8;
	localparam int CMD_RW_POS = 9;
	localparam int CTRL_PULSE_POS = 0;
	localparam int CTRL_WAIT_POS = 1;
	localparam int CTRL_RESET_POS = 2;
	localparam int STAT_BUSY_POS = 0;
	localparam int STAT_REFUSED_POS = 1;
	localparam int STAT_CALIBRATION_LOAD_MODE_POS = 2;
	localparam int STAT_LOADED_POS = 4;
	localparam int STAT_BURNED_POS = 16;
	typedef enum logic [2:0] {
		ST_SAVE = 3'b001,
		ST_NORMAL = 3'b010,
		ST_CALIBRATION_LOAD_MODE = 3'b100
	} dev_state_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_WAIT = 3'b010,
		HS_PULSE = 3'b100
	} host_state_t;
endpackage

/* File: src/otp_link_if.sv */
// Command byte and programming supply link between host and device
`timescale 1ns/1ps
interface otp_link_if;
	logic byte_valid;
	logic byte_dc;
	logic byte_rw;
	logic [7:0] byte_data;
	logic prog_supply;
	logic lcd_supply;
	logic ext_reset_n;
	modport host (
		output byte_valid,
		output byte_dc,
		output byte_rw,
		output byte_data,
		output prog_supply,
		output lcd_supply,
		output ext_reset_n
	);
	modport device (
		input byte_valid,
		input byte_dc,
		input byte_rw,
		input byte_data,
		input prog_supply,
		input lcd_supply,
		input ext_reset_n
	);
endinterface

/* File: src/otp_cell_array.sv */
// Calibration shift register and its one-time-programmable cells
`timescale 1ns/1ps
module otp_cell_array (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clear_en,
	input wire logic shift_en,
	input wire logic shift_bit,
	input wire logic load_en,
	input wire logic burn_en,
	output logic [8:0] shreg,
	output logic [8:0] cells
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shreg <= otp_pkg::RST_SHREG;
		end else if (clear_en) begin
			shreg <= otp_pkg::RST_SHREG;
		end else if (shift_en) begin
			shreg <= {shreg[7:0], shift_bit};
		end else if (load_en) begin
			shreg <= cells;
		end
	end

	// Cells only gain ones; a zero in the shift register leaves its cell alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cells <= otp_pkg::RST_CELLS;
		end else if (burn_en) begin
			cells <= cells | shreg;
		end
	end
endmodule // otp_cell_array

/* File: src/otp_host.sv */
// Host end: AHB-Lite register slave that sends bytes and times supply pulses
`timescale 1ns/1ps
module otp_host #(
	parameter int REFRESH_CYC = otp_pkg::REFRESH_CYC,
	parameter int PULSE_CYC = otp_pkg::PULSE_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	otp_link_if.host lnk
);
	localparam int MAXC = (PULSE_CYC > REFRESH_CYC) ? PULSE_CYC : REFRESH_CYC;
	localparam int CW = $clog2(MAXC + 1);
	localparam logic [CW-1:0] C_ONE = CW'(1);

	function automatic logic single_one(input logic [8:0] v);
		single_one = (v != 9'h000) && ((v & (v - 9'h001)) == 9'h000);
	endfunction

	otp_pkg::host_state_t st_r;
	logic [CW-1:0] cnt_r;
	logic wr_r;
	logic [31:0] addr_r;
	logic [31:0] rd_r;
	logic refused_r;
	logic cal_r;
	logic don_r;
	logic dal_r;
	logic [8:0] loaded_r;
	logic [8:0] burned_r;
	logic valid_r;
	logic dc_r;
	logic rw_r;
	logic [7:0] data_r;
	logic sup_r;
	logic rst_n_r;

	wire aphase = hsel & htrans[1] & hready;
	wire idle = (st_r == otp_pkg::HS_IDLE);
	wire w_cmd = wr_r & (addr_r == otp_pkg::REG_CMD);
	wire w_ctrl = wr_r & (addr_r == otp_pkg::REG_CTRL);
	wire w_stat = wr_r & (addr_r == otp_pkg::REG_STATUS);
	wire [7:0] wb = hwdata[7:0];
	wire send = w_cmd & idle;
	wire sent_cmd = send & ~hwdata[otp_pkg::CMD_DC_POS] & ~hwdata[otp_pkg::CMD_RW_POS];
	wire want_pulse = w_ctrl & hwdata[otp_pkg::CTRL_PULSE_POS];
	wire want_wait = w_ctrl & hwdata[otp_pkg::CTRL_WAIT_POS] & idle;
	wire want_rst = w_ctrl & hwdata[otp_pkg::CTRL_RESET_POS] & idle;
	// Pulse only in mode and power-down, one new cell, none already burned
	wire pulse_ok = idle & cal_r & ~don_r & dal_r & single_one(loaded_r) & ((loaded_r & burned_r) == 9'h000);
	wire go_pulse = want_pulse & pulse_ok;
	wire refuse = (w_cmd & ~idle) | (want_pulse & ~pulse_ok);
	wire cnt_end = (cnt_r == C_ONE);
	wire [31:0] stat_word = {7'h00, burned_r, 3'h0, loaded_r, 1'b0, cal_r, refused_r, ~idle};
	wire [31:0] rd_mux = (haddr == otp_pkg::REG_STATUS) ? stat_word : 32'h0000_0000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r <= 1'b0;
			addr_r <= '0;
			rd_r <= '0;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			wr_r <= aphase & hwrite;
			addr_r <= haddr;
			rd_r <= (aphase & ~hwrite) ? rd_mux : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Waits for refresh or times the supply pulse, each started from idle by its own request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= otp_pkg::HS_IDLE;
			cnt_r <= '0;
		end else begin
			case (st_r)
				otp_pkg::HS_IDLE: begin
					if (go_pulse) begin
						st_r <= otp_pkg::HS_PULSE;
						cnt_r <= CW'(PULSE_CYC);
					end else if (want_wait) begin
						st_r <= otp_pkg::HS_WAIT;
						cnt_r <= CW'(REFRESH_CYC);
					end
				end
				otp_pkg::HS_WAIT, otp_pkg::HS_PULSE: begin
					cnt_r <= cnt_r - C_ONE;
					if (cnt_end) begin
						st_r <= otp_pkg::HS_IDLE;
					end
				end
				default: begin
					st_r <= otp_pkg::HS_IDLE;
				end
			endcase
		end
	end

	// Mirror of what the device was told; the refused flag lets a new event win
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			refused_r <= 1'b0;
			cal_r <= 1'b0;
			don_r <= otp_pkg::RST_DON;
			dal_r <= otp_pkg::RST_DAL;
			loaded_r <= otp_pkg::RST_SHREG;
			burned_r <= otp_pkg::RST_CELLS;
		end else begin
			refused_r <= refuse | (refused_r & ~(w_stat & hwdata[otp_pkg::STAT_REFUSED_POS]));
			if (want_rst) begin
				cal_r <= 1'b0;
				don_r <= otp_pkg::RST_DON;
				dal_r <= otp_pkg::RST_DAL;
				loaded_r <= otp_pkg::RST_SHREG;
			end else if (sent_cmd) begin
				if (cal_r) begin
					loaded_r <= {loaded_r[7:0], wb[otp_pkg::DATA_POS]};
					cal_r <= wb[otp_pkg::CONT_POS];
				end else if (wb == otp_pkg::CMD_CALIBRATION_LOAD_MODE) begin
					cal_r <= ~burned_r[otp_pkg::SEAL_POS];
				end else if ((wb & otp_pkg::CMD_DISP_MASK) == otp_pkg::CMD_DISP_VAL) begin
					don_r <= wb[otp_pkg::DON_POS];
				end else if ((wb & otp_pkg::CMD_DAL_MASK) == otp_pkg::CMD_DAL_VAL) begin
					dal_r <= wb[otp_pkg::DAL_POS];
				end
			end
			if ((st_r == otp_pkg::HS_PULSE) && cnt_end) begin
				burned_r <= burned_r | loaded_r;
			end
		end
	end

	// Link outputs; supplies stay high for the whole pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_r <= 1'b0;
			dc_r <= 1'b0;
			rw_r <= 1'b0;
			data_r <= 8'h00;
			sup_r <= 1'b0;
			rst_n_r <= 1'b1;
		end else begin
			valid_r <= send;
			if (send) begin
				dc_r <= hwdata[otp_pkg::CMD_DC_POS];
				rw_r <= hwdata[otp_pkg::CMD_RW_POS];
				data_r <= wb;
			end
			sup_r <= go_pulse | ((st_r == otp_pkg::HS_PULSE) & ~cnt_end);
			rst_n_r <= ~want_rst;
		end
	end

	assign hrdata = rd_r;
	assign lnk.byte_valid = valid_r;
	assign lnk.byte_dc = dc_r;
	assign lnk.byte_rw = rw_r;
	assign lnk.byte_data = data_r;
	assign lnk.prog_supply = sup_r;
	assign lnk.lcd_supply = sup_r;
	assign lnk.ext_reset_n = rst_n_r;
endmodule // otp_host

/* File: testbench/otp_calibration_programming_asserts.sv */
// Link and calibration output assertions for the host and device pair
`timescale 1ns/1ps
module otp_calibration_programming_asserts #(
	parameter int PULSE_CYC = 30
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic prog_supply,
	input wire logic lcd_supply,
	input wire logic ext_reset_n,
	input wire logic cal_mode,
	input wire logic display_on,
	input wire logic all_pixels,
	input wire logic refresh_done,
	input wire logic [4:0] contrast_trim,
	input wire logic [2:0] temp_coeff_trim,
	input wire logic seal,
	input wire logic [8:0] otp_cells
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic [8:0] shreg = {contrast_trim, temp_coeff_trim, seal};
	wire logic entry_cmd = byte_valid && byte_data == otp_pkg::CMD_CALIBRATION_LOAD_MODE && !cal_mode;
	int pulse_cnt_r;
	// Counts cycles of the present supply pulse
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_cnt_r <= 0;
		end else begin
			pulse_cnt_r <= prog_supply ? pulse_cnt_r + 1 : 0;
		end
	end
	supply_pair_a: assert property (prog_supply == lcd_supply)
		else $error("supplies differ");
	supply_state_a: assert property ($rose(prog_supply) |-> cal_mode && !display_on && all_pixels)
		else $error("supply raised outside power-down mode");
	pulse_len_a: assert property ($fell(prog_supply) |-> pulse_cnt_r == PULSE_CYC)
		else $error("pulse length wrong");
	cell_keep_a: assert property ((otp_cells & $past(otp_cells)) == $past(otp_cells))
		else $error("burned cell cleared");
	burn_zero_a: assert property ((otp_cells & ~$past(otp_cells) & ~$past(shreg)) == 9'h000)
		else $error("cell burned without a loaded one");
	burn_cause_a: assert property ($changed(otp_cells) |-> $past(prog_supply))
		else $error("cell burned without supply");
	burn_one_a: assert property ((prog_supply && cal_mode) [*3] |-> (otp_cells & shreg) == shreg)
		else $error("loaded one not burned");
	mode_exit_a: assert property (cal_mode && byte_valid && !byte_data[7] |-> ##[1:3] !cal_mode)
		else $error("mode kept after exit byte");
	ext_clear_a: assert property (!ext_reset_n |-> ##[1:2] (!cal_mode && !refresh_done))
		else $error("external reset did not clear mode");
	sealed_entry_a: assert property (entry_cmd && seal |=> !cal_mode [*3])
		else $error("entry taken with seal set");
	early_entry_a: assert property (entry_cmd && !refresh_done |=> !cal_mode [*3])
		else $error("entry taken before refresh");
endmodule // otp_calibration_programming_asserts

/* File: testbench/otp_calibration_programming_bench.sv */
// Bench driving the host end over AHB-Lite, facing the device end
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module otp_calibration_programming_bench;
	localparam int REF = 20;
	localparam int PUL = 30;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, cal_mode, refresh_busy, refresh_done, display_on, all_pixels, seal;
	logic [1:0] power_bits;
	logic [4:0] contrast_trim;
	logic [2:0] temp_coeff_trim;
	logic [8:0] otp_cells;
	int fail_count = 0;
	int total_checks = 0;
	otp_link_if lnk ();
	always #10 hclk = ~hclk;
	otp_host #(.REFRESH_CYC(REF), .PULSE_CYC(PUL)) i_otp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .lnk(lnk.host));
	otp_device #(.REFRESH_CYC(REF)) i_otp_device (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.device),
		.cal_mode(cal_mode), .refresh_busy(refresh_busy), .refresh_done(refresh_done), .display_on(display_on),
		.all_pixels(all_pixels), .power_bits(power_bits), .contrast_trim(contrast_trim),
		.temp_coeff_trim(temp_coeff_trim), .seal(seal), .otp_cells(otp_cells));
	otp_calibration_programming_asserts #(.PULSE_CYC(PUL)) i_otp_calibration_programming_asserts (.hclk(hclk),
		.hresetn(hresetn), .byte_valid(lnk.byte_valid), .byte_data(lnk.byte_data), .prog_supply(lnk.prog_supply),
		.lcd_supply(lnk.lcd_supply), .ext_reset_n(lnk.ext_reset_n), .cal_mode(cal_mode), .display_on(display_on),
		.all_pixels(all_pixels), .refresh_done(refresh_done), .contrast_trim(contrast_trim),
		.temp_coeff_trim(temp_coeff_trim), .seal(seal), .otp_cells(otp_cells));
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		xfer(a, 1'b1, v, rd);
	endtask
	task automatic cmd(input logic [7:0] b);
		wr(otp_pkg::REG_CMD, {24'h00_0000, b});
	endtask
	// Polls status until the host is no longer waiting or pulsing
	task automatic idle();
		for (int i = 0; i < 100; i++) begin
			xfer(otp_pkg::REG_STATUS, 1'b0, 32'h0000_0000, rd);
			if (rd[otp_pkg::STAT_BUSY_POS] === 1'b0) break;
		end
	endtask
	task automatic pulse();
		wr(otp_pkg::REG_CTRL, 32'h0000_0001);
		idle();
	endtask
	task automatic enter();
		cmd(otp_pkg::CMD_EXIT_SAVE);
		wr(otp_pkg::REG_CTRL, 32'h0000_0002);
		idle();
		cmd(8'hA9);
		cmd(8'hA5);
		cmd(otp_pkg::CMD_CALIBRATION_LOAD_MODE);
		repeat (4) @(posedge hclk);
	endtask
	// Nine bytes, first bit first, with noise in the ignored bits
	task automatic load(input logic [8:0] p);
		for (int i = 8; i >= 0; i--) begin
			cmd({1'b1, 6'h2A, p[i]});
		end
		repeat (4) @(posedge hclk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		xfer(otp_pkg::REG_STATUS, 1'b0, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		wr(32'h0000_0010, 32'hFFFF_FFFF);
		xfer(32'h0000_0010, 1'b0, 32'h0000_0000, rd);
		`CHK(rd, 32'h0000_0000)
		cmd(otp_pkg::CMD_CALIBRATION_LOAD_MODE);
		repeat (4) @(posedge hclk);
		`CHK(cal_mode, 1'b0)
		cmd(8'h2B);
		repeat (4) @(posedge hclk);
		`CHK(power_bits, 2'h1)
		`CHK(refresh_busy, 1'b0)
		`CHK(hresp, 1'b0)
		$display("test early_entry done");
		enter();
		`CHK(refresh_done, 1'b1)
		`CHK(display_on, 1'b0)
		`CHK(all_pixels, 1'b1)
		`CHK(cal_mode, 1'b1)
		load(9'h011);
		`CHK({contrast_trim, temp_coeff_trim, seal}, 9'h011)
		xfer(otp_pkg::REG_STATUS, 1'b0, 32'h0000_0000, rd);
		`CHK(rd[12:4], 9'h011)
		pulse();
		`CHK(rd[otp_pkg::STAT_REFUSED_POS], 1'b1)
		`CHK(otp_cells, 9'h000)
		wr(otp_pkg::REG_STATUS, 32'h0000_0002);
		load(9'h100);
		pulse();
		`CHK(otp_cells, 9'h100)
		load(9'h008);
		pulse();
		`CHK(otp_cells, 9'h108)
		load(9'h100);
		pulse();
		`CHK(rd[otp_pkg::STAT_REFUSED_POS], 1'b1)
		`CHK(otp_cells, 9'h108)
		$display("test burn done");
		wr(otp_pkg::REG_CTRL, 32'h0000_0004);
		repeat (4) @(posedge hclk);
		`CHK(cal_mode, 1'b0)
		`CHK(refresh_done, 1'b0)
		`CHK(otp_cells, 9'h108)
		enter();
		`CHK({contrast_trim, temp_coeff_trim, seal}, 9'h108)
		cmd(8'h00);
		repeat (4) @(posedge hclk);
		`CHK(cal_mode, 1'b0)
		cmd(otp_pkg::CMD_CALIBRATION_LOAD_MODE);
		load(9'h001);
		`CHK(cal_mode, 1'b1)
		pulse();
		`CHK(otp_cells, 9'h109)
		$display("test exit_and_seal done");
		wr(otp_pkg::REG_CTRL, 32'h0000_0004);
		repeat (4) @(posedge hclk);
		enter();
		`CHK(seal, 1'b1)
		`CHK(cal_mode, 1'b0)
		$display("test sealed done");
		conclude();
	end
endmodule // otp_calibration_programming_bench
